// ---- src/smw_consts.svh ----
/*
  Shared memory window: offsets, field positions, reset values and codes.
  Assumes inclusion by bare name from the design files of both ends.
*/
`ifndef SMW_CONSTS_SVH
`define SMW_CONSTS_SVH

// ****************************************************************
// Window fields and address slicing
// ****************************************************************
`define SMW_FLD_HI       15       // Start / end field top bit
`define SMW_FLD_LO       7        // Start / end field bottom bit
`define SMW_CNT_HI       5        // Count field top bit
`define SMW_BP_HI        21       // Backplane address top bit
`define SMW_BLK_LSB      13       // First bit above an 8 KB block
`define SMW_BLK_MAX      7'h40    // 64 blocks fill the local RAM
`define SMW_EN_BIT       2        // Window enable in board control

// ****************************************************************
// Two-port file mailboxes and codes
// ****************************************************************
`define SMW_MB_CMD       2'h0
`define SMW_MB_STS       2'h1
`define SMW_MB_START     2'h2
`define SMW_MB_COUNT     2'h3
`define SMW_STS_WAIT     3'h4     // Waiting for command
`define SMW_STS_BUSY     3'h0     // Command in progress
`define SMW_STS_RST      16'h0004
`define SMW_CMD_ENABLE   16'h0040
`define SMW_CMD_DISABLE  16'h0100
`define SMW_ERR_MULTI    15       // More than one command bit set
`define SMW_ERR_UNKNOWN  14       // Single unsupported command bit

// ****************************************************************
// Local register port selectors
// ****************************************************************
`define SMW_LOC_START    2'h0
`define SMW_LOC_ENDCNT   2'h1
`define SMW_LOC_CTRL     2'h2

// ****************************************************************
// Arbiter AHB-Lite register offsets (low address byte)
// ****************************************************************
`define SMW_A_START      8'h00
`define SMW_A_COUNT      8'h04
`define SMW_A_RAWCMD     8'h08
`define SMW_A_ORDER      8'h0C
`define SMW_A_STATUS     8'h10
`define SMW_A_PROBE      8'h14
`define SMW_A_PROBE_RES  8'h18
`define SMW_ORD_EN       0
`define SMW_ORD_DIS      1
`define SMW_ORD_RAW      2

`endif

// ---- src/smw_pkg.sv ----
/*
  Shared memory window: state types for both ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smw_pkg;

  // Device command engine, Gray along wait -> exec
  typedef enum logic [1:0] {
    smw_ds_wait = 2'b00,
    smw_ds_exec = 2'b01
  } smw_dev_state_type;

  // Arbiter sequencer, Gray along the enable path
  typedef enum logic [2:0] {
    smw_as_idle  = 3'b000,
    smw_as_ready = 3'b001,
    smw_as_start = 3'b011,
    smw_as_count = 3'b010,
    smw_as_cmd   = 3'b110
  } smw_arb_state_type;

endpackage

// ---- src/smw_link_if.sv ----
/*
  Shared memory window link: two-port file mailboxes and backplane probe.
  Assumes both ends run on the same hclk; the bench instantiates it.
*/
`timescale 1ns/10ps
interface smw_link_if;
  logic        tp_wr;        // One-cycle mailbox write strobe
  logic [1:0]  tp_sel;       // Mailbox selector
  logic [15:0] tp_wdata;     // Mailbox write data
  logic [15:0] cmd_mbx;      // Command mailbox contents
  logic [15:0] sts_mbx;      // Status mailbox contents
  logic        bp_valid;     // Backplane address is meaningful
  logic [21:0] bp_addr;      // Backplane byte address
  logic        bp_hit;       // Address falls in the enabled window
  logic [18:0] bp_ram_addr;  // Local RAM byte address for a hit

  modport dev (
    input  tp_wr, tp_sel, tp_wdata, bp_valid, bp_addr,
    output cmd_mbx, sts_mbx, bp_hit, bp_ram_addr
  );
  modport arb (
    output tp_wr, tp_sel, tp_wdata, bp_valid, bp_addr,
    input  cmd_mbx, sts_mbx, bp_hit, bp_ram_addr
  );
endinterface // smw_link_if

// ---- src/smw_device.sv ----
/*
  Shared memory window, board end: window registers, board control enable,
  mailbox command engine and backplane-to-local address translation.
  Assumes one clock hclk, a board power-on reset and a local reset.
*/
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "smw_consts.svh"

module smw_device (
  // Clock, resets and enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_n,
  input  wire logic        ce,
  // Link to the arbiter
  smw_link_if.dev          link,
  // Local processor register port
  input  wire logic        loc_wr,
  input  wire logic [1:0]  loc_addr,
  input  wire logic [15:0] loc_wdata,
  output logic      [15:0] loc_rdata,
  // Remote debugger
  input  wire logic        rmt_go,
  // Window state
  output logic             win_en
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [8:0]                 start_q;
  logic [8:0]                 end_q;
  logic [5:0]                 cnt_q;
  logic                       en_q;
  logic [15:0]                cmd_q;
  logic [15:0]                sts_q;
  logic [15:0]                spar_q;
  logic [15:0]                cpar_q;
  logic [15:0]                rdata_q;
  logic                       hit_q;
  logic [18:0]                ram_addr_q;
  smw_pkg::smw_dev_state_type state_q;

  logic                       exec_en;
  logic                       exec_dis;
  logic                       cmd_multi;
  logic [8:0]                 bp_blk;
  logic [8:0]                 blk_off;
  logic [5:0]                 ndec;
  logic [6:0]                 nblk;
  logic                       hit_d;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  // Only a command word with exactly one set bit is acted on
  assign cmd_multi = (cmd_q & (cmd_q - 16'h0001)) != 16'h0000;
  assign exec_en   = (state_q == smw_pkg::smw_ds_exec) && (cmd_q == `SMW_CMD_ENABLE);
  assign exec_dis  = (state_q == smw_pkg::smw_ds_exec) && (cmd_q == `SMW_CMD_DISABLE);

  // ****************************************************************
  // Window registers
  // ****************************************************************
  // Cleared only at power-on so that a local reset keeps them
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      start_q <= 9'h000;
      end_q   <= 9'h000;
      cnt_q   <= 6'h00;
    end else if (ce) begin
      if (exec_en) begin
        start_q <= spar_q[8:0];
        end_q   <= spar_q[8:0] + {3'h0, cpar_q[`SMW_CNT_HI:0]};
        cnt_q   <= 6'h00 - spar_q[5:0] - cpar_q[`SMW_CNT_HI:0] - 6'h01;
      end else if (loc_wr && loc_addr == `SMW_LOC_START) begin
        start_q <= loc_wdata[`SMW_FLD_HI:`SMW_FLD_LO];
      end else if (loc_wr && loc_addr == `SMW_LOC_ENDCNT) begin
        end_q <= loc_wdata[`SMW_FLD_HI:`SMW_FLD_LO];
        cnt_q <= loc_wdata[`SMW_CNT_HI:0];
      end
    end
  end

  // ****************************************************************
  // Board control enable
  // ****************************************************************
  // Debugger GO beats every other source of the enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;
    end else if (ce) begin
      if (rmt_go) begin
        en_q <= 1'b0;
      end else if (exec_en) begin
        en_q <= 1'b1;
      end else if (exec_dis) begin
        en_q <= 1'b0;
      end else if (loc_wr && loc_addr == `SMW_LOC_CTRL) begin
        en_q <= loc_wdata[`SMW_EN_BIT];
      end
    end
  end

  assign win_en = en_q;

  // ****************************************************************
  // Mailboxes written by the arbiter
  // ****************************************************************
  // An arbiter write in the clearing cycle wins, so no command is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q  <= 16'h0000;
      spar_q <= 16'h0000;
      cpar_q <= 16'h0000;
    end else if (ce) begin
      if (link.tp_wr && link.tp_sel == `SMW_MB_CMD) begin
        cmd_q <= link.tp_wdata;
      end else if (state_q == smw_pkg::smw_ds_exec) begin
        cmd_q <= 16'h0000;
      end
      if (link.tp_wr && link.tp_sel == `SMW_MB_START) begin
        spar_q <= link.tp_wdata;
      end
      if (link.tp_wr && link.tp_sel == `SMW_MB_COUNT) begin
        cpar_q <= link.tp_wdata;
      end
    end
  end

  // ****************************************************************
  // Command engine and status mailbox
  // ****************************************************************
  // One cycle busy, then back to waiting with error bits updated
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= smw_pkg::smw_ds_wait;
      sts_q   <= `SMW_STS_RST;
    end else if (ce) begin
      unique case (state_q)
        smw_pkg::smw_ds_wait: begin
          if (cmd_q != 16'h0000) begin
            sts_q[2:0] <= `SMW_STS_BUSY;
            state_q    <= smw_pkg::smw_ds_exec;
          end
        end
        smw_pkg::smw_ds_exec: begin
          sts_q[2:0] <= `SMW_STS_WAIT;
          state_q    <= smw_pkg::smw_ds_wait;
          if (cmd_multi) begin
            sts_q[`SMW_ERR_MULTI] <= 1'b1;
          end else if (exec_en || exec_dis) begin
            sts_q[`SMW_ERR_MULTI]   <= 1'b0;
            sts_q[`SMW_ERR_UNKNOWN] <= 1'b0;
          end else begin
            sts_q[`SMW_ERR_UNKNOWN] <= 1'b1;
          end
        end
      endcase
    end
  end

  assign link.cmd_mbx = cmd_q;
  assign link.sts_mbx = sts_q;

  // ****************************************************************
  // Local read-back
  // ****************************************************************
  // Unused low bits of start and bit 6 of end/count read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      unique case (loc_addr)
        `SMW_LOC_START:  rdata_q <= {start_q, 7'h00};
        `SMW_LOC_ENDCNT: rdata_q <= {end_q, 1'b0, cnt_q};
        `SMW_LOC_CTRL:   rdata_q <= {13'h0000, en_q, 2'h0};
        default:         rdata_q <= 16'h0000;
      endcase
    end
  end

  assign loc_rdata = rdata_q;

  // ****************************************************************
  // Backplane translation
  // ****************************************************************
  // Count field decodes back to 1..64 blocks; zero stands for all 64
  assign ndec    = 6'h00 - cnt_q - start_q[5:0];
  assign nblk    = (ndec == 6'h00) ? `SMW_BLK_MAX : {1'b0, ndec};
  assign bp_blk  = link.bp_addr[`SMW_BP_HI:`SMW_BLK_LSB];
  assign blk_off = bp_blk - start_q;
  // Window bounds come from the registers alone
  assign hit_d   = en_q && link.bp_valid && (bp_blk >= start_q) && (bp_blk <= end_q)
                   && (blk_off < {2'h0, nblk});

  // Base block is 64 - N, so local block is offset minus N mod 64
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_q      <= 1'b0;
      ram_addr_q <= 19'h0_0000;
    end else if (ce) begin
      hit_q      <= hit_d;
      ram_addr_q <= {blk_off[5:0] - nblk[5:0],
                     link.bp_addr[`SMW_BLK_LSB-1:0]};
    end
  end

  assign link.bp_hit      = hit_q;
  assign link.bp_ram_addr = ram_addr_q;

endmodule // smw_device

// ---- src/smw_arbiter.sv ----
/*
  Shared memory window, arbiter end: AHB-Lite register slave that turns
  software orders into mailbox sequences, plus a backplane address probe.
  Assumes a single AHB-Lite master on hclk and the device on the link.
*/
`timescale 1ns/10ps
`include "smw_consts.svh"

module smw_arbiter (
  // Clock, reset and enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Link to the device
  smw_link_if.arb          link
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [8:0]                 spar_q;
  logic [5:0]                 cpar_q;
  logic [15:0]                raw_q;
  logic [21:0]                probe_q;
  logic                       probe_v_q;
  logic [2:0]                 ord_q;
  logic                       wr_pend_q;
  logic [7:0]                 addr_q;
  logic [31:0]                rdata_q;
  logic                       tp_wr_q;
  logic [1:0]                 tp_sel_q;
  logic [15:0]                tp_wdata_q;
  smw_pkg::smw_arb_state_type state_q;

  logic                       take;
  logic                       wr_now;
  logic                       ready;

  // ****************************************************************
  // AHB-Lite front end
  // ****************************************************************
  // Zero wait states; a frozen clock enable stalls the bus instead
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign take      = hsel && htrans[1] && hready;
  assign wr_now    = wr_pend_q && ce;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
      if (take && !hwrite) begin
        unique case (haddr[7:0])
          `SMW_A_START:     rdata_q <= {23'h00_0000, spar_q};
          `SMW_A_COUNT:     rdata_q <= {26'h000_0000, cpar_q};
          `SMW_A_RAWCMD:    rdata_q <= {16'h0000, raw_q};
          `SMW_A_ORDER:     rdata_q <= {31'h0000_0000, state_q != smw_pkg::smw_as_idle};
          `SMW_A_STATUS:    rdata_q <= {link.cmd_mbx, link.sts_mbx};
          `SMW_A_PROBE:     rdata_q <= {10'h000, probe_q};
          `SMW_A_PROBE_RES: rdata_q <= {12'h000, link.bp_hit, link.bp_ram_addr};
          default:          rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Parameter registers
  // ****************************************************************
  // Upper mailbox bits are sent as zero, so only the fields are kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spar_q    <= 9'h000;
      cpar_q    <= 6'h00;
      raw_q     <= 16'h0000;
      probe_q   <= 22'h00_0000;
      probe_v_q <= 1'b0;
    end else if (wr_now) begin
      if (addr_q == `SMW_A_START) begin
        spar_q <= hwdata[8:0];
      end
      if (addr_q == `SMW_A_COUNT) begin
        cpar_q <= hwdata[`SMW_CNT_HI:0];
      end
      if (addr_q == `SMW_A_RAWCMD) begin
        raw_q <= hwdata[15:0];
      end
      if (addr_q == `SMW_A_PROBE) begin
        probe_q   <= hwdata[`SMW_BP_HI:0];
        probe_v_q <= 1'b1;
      end
    end
  end

  assign link.bp_addr  = probe_q;
  assign link.bp_valid = probe_v_q;

  // ****************************************************************
  // Mailbox sequencer
  // ****************************************************************
  // Orders arriving while busy are dropped rather than queued
  assign ready = (link.sts_mbx[2:0] == `SMW_STS_WAIT)
                 && (link.cmd_mbx == 16'h0000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= smw_pkg::smw_as_idle;
      ord_q      <= 3'h0;
      tp_wr_q    <= 1'b0;
      tp_sel_q   <= `SMW_MB_CMD;
      tp_wdata_q <= 16'h0000;
    end else if (ce) begin
      tp_wr_q <= 1'b0;
      unique case (state_q)
        smw_pkg::smw_as_idle: begin
          if (wr_pend_q && addr_q == `SMW_A_ORDER && hwdata[2:0] != 3'h0) begin
            ord_q   <= hwdata[2:0];
            state_q <= smw_pkg::smw_as_ready;
          end
        end
        smw_pkg::smw_as_ready: begin
          if (ready) begin
            state_q <= ord_q[`SMW_ORD_EN] ? smw_pkg::smw_as_start : smw_pkg::smw_as_cmd;
          end
        end
        smw_pkg::smw_as_start: begin
          tp_wr_q    <= 1'b1;
          tp_sel_q   <= `SMW_MB_START;
          tp_wdata_q <= {7'h00, spar_q};
          state_q    <= smw_pkg::smw_as_count;
        end
        smw_pkg::smw_as_count: begin
          tp_wr_q    <= 1'b1;
          tp_sel_q   <= `SMW_MB_COUNT;
          tp_wdata_q <= {10'h000, cpar_q};
          state_q    <= smw_pkg::smw_as_cmd;
        end
        smw_pkg::smw_as_cmd: begin
          tp_wr_q  <= 1'b1;
          tp_sel_q <= `SMW_MB_CMD;
          if (ord_q[`SMW_ORD_EN]) begin
            tp_wdata_q <= `SMW_CMD_ENABLE;
          end else if (ord_q[`SMW_ORD_DIS]) begin
            tp_wdata_q <= `SMW_CMD_DISABLE;
          end else begin
            tp_wdata_q <= raw_q;
          end
          state_q <= smw_pkg::smw_as_idle;
        end
        default: begin
          state_q <= smw_pkg::smw_as_idle;
        end
      endcase
    end
  end

  assign link.tp_wr    = tp_wr_q;
  assign link.tp_sel   = tp_sel_q;
  assign link.tp_wdata = tp_wdata_q;

endmodule // smw_arbiter

// ---- verif/smw_props.sv ----
/*
  Checker for the shared window link: mailbox handshake and probe.
  Assumes one clock hclk and the link signals, instantiated by tb_top.
*/
`timescale 1ns/10ps
module smw_props (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Mailbox side
  input wire logic        tp_wr,
  input wire logic [1:0]  tp_sel,
  input wire logic [15:0] tp_wdata,
  input wire logic [15:0] cmd_mbx,
  input wire logic [15:0] sts_mbx,
  // Probe side
  input wire logic        bp_valid,
  input wire logic [21:0] bp_addr,
  input wire logic        bp_hit,
  input wire logic [18:0] bp_ram_addr
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A command write in flight would legally override the device's clear
  logic cmd_wr;
  assign cmd_wr = tp_wr && tp_sel == 2'h0;

  AST_EXEC_START: assert property ((sts_mbx[2:0] == 3'h4 && cmd_mbx != 0) |=>
    sts_mbx[2:0] == 3'h0) else $error("busy status missing");
  AST_EXEC_DONE: assert property ((sts_mbx[2:0] == 3'h0 && !cmd_wr) |=>
    (sts_mbx[2:0] == 3'h4 && cmd_mbx == 0)) else $error("no return to waiting");
  AST_MULTI_ERR: assert property ((sts_mbx[2:0] == 3'h4 && $countones(cmd_mbx) > 1
    && !cmd_wr) |-> ##2 sts_mbx[15]) else $error("multi-bit command not flagged");
  AST_ENABLE_SEQ: assert property ((tp_wr && tp_sel == 2'h2) |=> (tp_wr && tp_sel == 2'h3)
    ##1 (cmd_wr && tp_wdata == 16'h0040)) else $error("enable sequence broken");
  AST_START_HI_ZERO: assert property ((tp_wr && tp_sel == 2'h2) |->
    tp_wdata[15:9] == 0) else $error("start mailbox upper bits set");
  AST_COUNT_HI_ZERO: assert property ((tp_wr && tp_sel == 2'h3) |->
    tp_wdata[15:6] == 0) else $error("count mailbox upper bits set");
  AST_ORDER_WAIT: assert property ((tp_wr && tp_sel == 2'h2) |->
    ($past(sts_mbx[2:0]) == 3'h4 && $past(cmd_mbx) == 0)) else $error("command before waiting");
  AST_HIT_OFFSET: assert property (bp_hit |->
    bp_ram_addr[12:0] == $past(bp_addr[12:0])) else $error("in-block offset lost");
  AST_HIT_VALID: assert property (bp_hit |-> $past(bp_valid))
    else $error("hit without probe");

  // Main scenarios reached
  cover property (tp_wr && tp_sel == 2'h2);
  cover property (bp_hit);
  cover property (sts_mbx[15]);
endmodule // smw_props

// ---- verif/tb_top.sv ----
/*
  Self-checking bench: arbiter and device joined by the link interface.
  Assumes the design sources and smw_consts.svh on the include path.
*/
`timescale 1ns/10ps
`include "smw_consts.svh"
module tb_top;
  // Clock, resets and local port
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        por_n     = 1'b0;
  logic        loc_wr    = 1'b0;
  logic [1:0]  loc_addr  = 2'h0;
  logic [15:0] loc_wdata = 16'h0000;
  logic [15:0] loc_rdata;
  logic        rmt_go    = 1'b0;
  logic        ce        = 1'b1;
  logic        win_en;
  // AHB-Lite master
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  // Model state
  int          err_total = 0;
  int          checked   = 0;
  int          cyc       = 0;
  int          seed      = 87;
  int          s, n, o, i;
  logic [31:0] r, a;
  int          nq[$]     = '{1, 2, 64, 0};

  always #25 hclk = ~hclk;

  smw_link_if link ();
  smw_device smw_device_i (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .ce(ce),
    .link(link), .loc_wr(loc_wr), .loc_addr(loc_addr), .loc_wdata(loc_wdata),
    .loc_rdata(loc_rdata), .rmt_go(rmt_go), .win_en(win_en));
  smw_arbiter smw_arbiter_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  smw_props smw_props_i (.hclk(hclk), .hresetn(hresetn), .tp_wr(link.tp_wr),
    .tp_sel(link.tp_sel), .tp_wdata(link.tp_wdata), .cmd_mbx(link.cmd_mbx),
    .sts_mbx(link.sts_mbx), .bp_valid(link.bp_valid), .bp_addr(link.bp_addr),
    .bp_hit(link.bp_hit), .bp_ram_addr(link.bp_ram_addr));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("Checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One single transfer; the slave's own hready paces both phases
  task ahb(input logic [7:0] ad, input logic wr, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= 32'(ad);
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task probe(input logic [31:0] pa);
    ahb(`SMW_A_PROBE, 1'b1, pa);
    ahb(`SMW_A_PROBE_RES, 1'b0, 32'h0000_0000);
  endtask
  task lrd(input logic [1:0] ad);
    @(posedge hclk);
    loc_addr <= ad;
    repeat (2) @(posedge hclk);
    r = 32'(loc_rdata);
  endtask
  task lwr(input logic [1:0] ad, input logic [15:0] d);
    @(posedge hclk);
    loc_wr    <= 1'b1;
    loc_addr  <= ad;
    loc_wdata <= d;
    @(posedge hclk);
    loc_wr    <= 1'b0;
  endtask
  // Bounded wait on the enable, then the status word over the bus
  task wen(input logic v);
    for (i = 0; i < 60 && win_en !== v; i++) @(posedge hclk);
    chk("win_en", 32'(win_en), 32'(v));
    ahb(`SMW_A_STATUS, 1'b0, 32'h0000_0000);
  endtask

  // Hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    por_n   <= 1'b1;
    @(posedge hclk);
    chk("mailboxes", {link.cmd_mbx, link.sts_mbx}, 32'h0000_0004);
    chk("hresp", 32'(hresp), 32'h0000_0000);
    // Window sizes 1, 2 and 64 from both ends of the range plus a random one
    foreach (nq[j]) begin
      n = (nq[j] != 0) ? nq[j] : 1 + $unsigned($random(seed)) % 64;
      // Window kept inside the 22-bit space, clear of other responders
      s = $unsigned($random(seed)) % (513 - n);
      ahb(`SMW_A_START, 1'b1, 32'(s));
      ahb(`SMW_A_COUNT, 1'b1, 32'(n - 1));
      ahb(`SMW_A_ORDER, 1'b1, 32'h0000_0001);
      wen(1'b1);
      chk("status", r, 32'h0000_0004);
      lrd(`SMW_LOC_START);
      chk("start", r, 32'(s << 7));
      lrd(`SMW_LOC_ENDCNT);
      chk("endcnt", r, 32'(((s + n - 1) << 7) | ((-(s + n)) & 63)));
      o = $unsigned($random(seed)) % n;
      a = $random(seed) & 32'h0000_1FFF;
      probe(32'(((s + o) << 13)) | a);
      chk("hit", r, 32'((1 << 19) | ((64 - n + o) << 13)) | a);
      probe(32'((s + n) << 13));
      chk("beyond", r, 32'h0000_0000);
      // Disable each time, so the next enable is seen as a real change
      ahb(`SMW_A_ORDER, 1'b1, 32'h0000_0002);
      wen(1'b0);
      chk("status", r, 32'h0000_0004);
      probe(32'(s << 13));
      chk("off", r, 32'(((64 - n) & 63) << 13));
    end
    ahb(`SMW_A_START, 1'b0, 32'h0000_0000);
    chk("spar", r, 32'(s));
    // Local enable, then local reset and debugger GO clear it only
    lwr(`SMW_LOC_CTRL, 16'h0004);
    wen(1'b1);
    lrd(`SMW_LOC_CTRL);
    chk("ctrl", r, 32'h0000_0004);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    wen(1'b0);
    lrd(`SMW_LOC_START);
    chk("kept", r, 32'(s << 7));
    lwr(`SMW_LOC_CTRL, 16'h0004);
    wen(1'b1);
    // A low clock enable must hold the enable against debugger GO
    @(posedge hclk);
    ce     <= 1'b0;
    rmt_go <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("frozen", 32'(win_en), 32'h0000_0001);
    ce     <= 1'b1;
    @(posedge hclk);
    rmt_go <= 1'b0;
    wen(1'b0);
    // Two command bits at once: flagged, not executed
    ahb(`SMW_A_RAWCMD, 1'b1, 32'h0000_0140);
    ahb(`SMW_A_ORDER, 1'b1, 32'h0000_0004);
    for (i = 0; i < 60 && link.sts_mbx[15] !== 1'b1; i++) @(posedge hclk);
    wen(1'b0);
    chk("error", r, 32'h0000_8004);
    // Single unsupported command bit: flagged apart, back to waiting
    ahb(`SMW_A_RAWCMD, 1'b1, 32'h0000_0001);
    ahb(`SMW_A_ORDER, 1'b1, 32'h0000_0004);
    for (i = 0; i < 60 && link.sts_mbx[14] !== 1'b1; i++) @(posedge hclk);
    wen(1'b0);
    chk("unknown", r, 32'h0000_C004);
    summarize;
  end
endmodule // tb_top
